// ==== logic/cbo_bus_ops.v ====
// Coherency-side bus operation engine: issue, snoop, push and data grant steering
`timescale 1ns/1ps
`include "cbo_defines.vh"
module cbo_bus_ops (
  // Clock and reset
  input  wire                  ref_clk_in,
  input  wire                  rst_in,
  // Instruction issue side
  input  wire                  op_valid_in,
  input  wire [`CBO_OP_W-1:0]  op_code_in,
  input  wire [`CBO_AW-1:0]    op_paddr_in,
  input  wire [`CBO_DW-1:0]    op_wdata_in,
  input  wire                  op_burst_in,
  input  wire [`CBO_TRANSFER_SIZE_BITS_W-1:0] op_size_in,
  output reg                   op_ready_out,
  output reg                   op_done_out,
  output reg  [`CBO_DW-1:0]    op_rdata_out,
  // Data cache tag port
  input  wire [`CBO_ST_W-1:0]  op_state_in,
  input  wire [`CBO_ST_W-1:0]  snp_state_in,
  output reg                   state_wr_out,
  output reg  [`CBO_AW-1:0]    state_addr_out,
  output reg  [`CBO_ST_W-1:0]  state_val_out,
  // Memory queue
  input  wire                  memq_empty_in,
  input  wire                  load_pending_in,
  input  wire                  store_pending_in,
  // Address bus master
  output reg                   abus_req_out,
  output reg  [`CBO_TT_W-1:0]  transfer_type_field_out,
  output reg  [`CBO_AW-1:0]    abus_addr_out,
  output reg                   burst_indicator_out,
  output reg  [`CBO_TRANSFER_SIZE_BITS_W-1:0] transfer_size_bits_out,
  output reg  [`CBO_RSEL_W-1:0] resource_selector_out,
  output reg                   push_req_out,
  input  wire                  abus_ack_in,
  input  wire                  address_retry_in,
  input  wire                  shared_response_in,
  // Snoop side
  input  wire                  snp_valid_in,
  input  wire [`CBO_TT_W-1:0]  snp_tt_in,
  input  wire [`CBO_AW-1:0]    snp_addr_in,
  output reg                   address_retry_out,
  // Data bus
  input  wire                  dbus_grant_in,
  input  wire                  write_only_data_grant_qualifier_n_in,
  input  wire [`CBO_DW-1:0]    dbus_data_in,
  output reg                   dbus_for_store_out,
  output reg                   dbus_for_load_out,
  output reg  [`CBO_DW-1:0]    dbus_data_out
);
  // Engine overview
  // Idle waits for an issued op and latches it with its address.
  // Drain holds a barrier until the memory queue has gone empty,
  // so that no earlier store can pass the barrier on the bus.
  // Address asks for the address bus and reissues on every retry;
  // our own snoop may retry us, which costs one more tenure only.
  // Data waits for the grant that carries the op's single word.
  // Silent ops never leave idle; they write the tag when the decoder asks, and finish.
  // Limitation: one op in flight, the issue side must wait.
  // Trade-off: no queue, so a retry stalls the issue stream.

  // Engine states, one-hot
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_ADDR = 4'h2;
  localparam [3:0] ST_DATA = 4'h4;
  localparam [3:0] ST_DRN  = 4'h8;

  // Decoder outputs
  wire                 dec_bus;        // Op needs a bus transaction
  wire [`CBO_TT_W-1:0] dec_tt;         // Transfer type for the op
  wire                 dec_wr;         // Op changes the block state
  wire [`CBO_ST_W-1:0] dec_st;         // Next block state
  wire                 dec_drain;      // Memory queue must drain first

  // Engine registers
  reg [3:0]            state_reg;      // Engine state
  reg [3:0]            state_next;
  reg [`CBO_OP_W-1:0]  opc_reg;        // Latched opcode
  reg [`CBO_DW-1:0]    wdata_reg;      // Word for external write
  reg                  wr_reg;         // Latched state-write flag
  reg [`CBO_ST_W-1:0]  nst_reg;        // Latched next state
  reg                  push_pend_reg;  // Snoop copy-back owed
  reg [`CBO_AW-1:0]    push_addr_reg;  // Address of owed copy-back
  reg                  snp_work_reg;   // Snoop maintenance in flight

  // Synchronised write-only qualifier (pin from the arbiter)
  reg [2:0]            write_only_data_grant_qualifier_sync_reg;  // Three-stage sampler
  reg                  write_only_data_grant_qualifier_reg;       // Filtered level, active high

  cbo_op_decode u_dec (
    .op_in          (op_code_in),
    .state_in       (op_state_in),
    .bus_op_out     (dec_bus),
    .tt_out         (dec_tt),
    .state_wr_out   (dec_wr),
    .state_next_out (dec_st),
    .drain_out      (dec_drain)
  );

  // Decode helpers used in several places
  function is_xfer;
    input [`CBO_OP_W-1:0] op;
    begin
      is_xfer = (op == `CBO_OP_XFER_RD) || (op == `CBO_OP_XFER_WR);
    end
  endfunction

  function is_cache_ctl_tt;
    input [`CBO_TT_W-1:0] tt;
    begin
      is_cache_ctl_tt = (tt == `CBO_TT_KILL) || (tt == `CBO_TT_FLUSH) || (tt == `CBO_TT_CLEAN) ||
                        (tt == `CBO_TT_ICBI) || (tt == `CBO_TT_WRITE_KILL);
    end
  endfunction

  // Snoop classification
  wire snp_hit_m  = snp_valid_in && (snp_state_in == `CBO_ST_M);
  wire snp_rnc    = snp_valid_in && (snp_tt_in == `CBO_TT_RD_NO_CACHE);
  wire snp_sync   = snp_valid_in && (snp_tt_in == `CBO_TT_SYNC);
  wire snp_ctl    = snp_valid_in && is_cache_ctl_tt(snp_tt_in) && (snp_state_in != `CBO_ST_I);
  // Any pipelined access hitting M while a read is out wants a push
  wire read_out   = (state_reg != ST_IDLE) && !is_xfer(opc_reg) && (opc_reg == `CBO_OP_DCBT);
  wire want_push  = snp_hit_m && (snp_rnc || read_out);
  wire op_take    = op_valid_in && op_ready_out;

  // Next-state logic
  // Only bus ops leave idle; a drain step comes first for barriers.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (op_take && dec_bus) begin
          state_next = dec_drain ? ST_DRN : ST_ADDR;
        end
      end
      ST_DRN: begin
        if (memq_empty_in) begin
          state_next = ST_ADDR;
        end
      end
      ST_ADDR: begin
        // A retry, even from our own snoop, simply reissues
        if (abus_ack_in && !address_retry_in) begin
          state_next = (is_xfer(opc_reg) || opc_reg == `CBO_OP_DCBT) ? ST_DATA : ST_IDLE;
        end
      end
      ST_DATA: begin
        if (dbus_grant_in) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Qualifier pin sampler: change counts once stages two and three agree
  // Pin comes from the arbiter's domain, so it is filtered first.
  // Cost: three to four cycles of lag before a grant can use it.
  // Stages reset to the pin's idle (high) level, so no false
  // assertion of the qualifier follows reset.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      write_only_data_grant_qualifier_sync_reg <= 3'h7;
      write_only_data_grant_qualifier_reg      <= 1'b0;
    end else begin
      write_only_data_grant_qualifier_sync_reg <= {write_only_data_grant_qualifier_sync_reg[1:0], write_only_data_grant_qualifier_n_in};
      if (write_only_data_grant_qualifier_sync_reg[1] == write_only_data_grant_qualifier_sync_reg[2]) begin
        write_only_data_grant_qualifier_reg <= ~write_only_data_grant_qualifier_sync_reg[2];
      end
    end
  end

  // Main sequential process
  // Snoop side runs every cycle, independent of the issue engine.
  // Tag writes from several sources share one port; later
  // assignments below win, so issue completion beats snoop work.
  // Hazard: a snoop and a completion to one block in one cycle
  // keep only the completion's write; the snoop's tag write is lost.
  // Push request follows the owed flag in the same cycle, so
  // the arbiter sees the copy-back one cycle after the snoop.
  // Push flag clear beats a new set when both fall together.
  // Data steering pulses are one cycle wide, one after a grant.
  // Qualifier uses the filtered level, never the raw pin.
  // Reset values are all constants; outputs idle low.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg               <= ST_IDLE;
      opc_reg                 <= {`CBO_OP_W{1'b0}};
      wdata_reg               <= {`CBO_DW{1'b0}};
      wr_reg                  <= 1'b0;
      nst_reg                 <= `CBO_ST_I;
      push_pend_reg           <= 1'b0;
      push_addr_reg           <= {`CBO_AW{1'b0}};
      snp_work_reg            <= 1'b0;
      op_ready_out            <= 1'b0;
      op_done_out             <= 1'b0;
      op_rdata_out            <= {`CBO_DW{1'b0}};
      state_wr_out            <= 1'b0;
      state_addr_out          <= {`CBO_AW{1'b0}};
      state_val_out           <= `CBO_ST_I;
      abus_req_out            <= 1'b0;
      transfer_type_field_out <= `CBO_TT_CLEAN;
      abus_addr_out           <= {`CBO_AW{1'b0}};
      burst_indicator_out     <= 1'b0;
      transfer_size_bits_out  <= {`CBO_TRANSFER_SIZE_BITS_W{1'b0}};
      resource_selector_out   <= {`CBO_RSEL_W{1'b0}};
      push_req_out            <= 1'b0;
      address_retry_out       <= 1'b0;
      dbus_for_store_out      <= 1'b0;
      dbus_for_load_out       <= 1'b0;
      dbus_data_out           <= {`CBO_DW{1'b0}};
    end else begin
      state_reg    <= state_next;
      op_done_out  <= 1'b0;
      state_wr_out <= 1'b0;
      op_ready_out <= (state_next == ST_IDLE);
      // Snoop response: retry a barrier while snoop work is pending
      address_retry_out <= snp_sync && (snp_work_reg || push_pend_reg);
      // Snoop maintenance on broadcast cache ops
      snp_work_reg <= snp_ctl;
      if (snp_ctl) begin
        state_wr_out   <= 1'b1;
        state_addr_out <= snp_addr_in;
        state_val_out  <= `CBO_ST_I;
      end
      // High-priority push may nest inside an outstanding read
      push_req_out <= push_pend_reg;
      // Copy-back on M hit by no-cache read (block kept as E) or while a read is out (block to I)
      if (want_push && !push_pend_reg) begin
        push_pend_reg  <= 1'b1;
        push_req_out   <= 1'b1;
        push_addr_reg  <= snp_addr_in;
        state_wr_out   <= 1'b1;
        state_addr_out <= snp_addr_in;
        state_val_out  <= snp_rnc ? `CBO_ST_E : `CBO_ST_I;
      end else if (push_pend_reg && abus_ack_in && push_req_out && !address_retry_in) begin
        // Push accepted without retry, release the request
        push_pend_reg <= 1'b0;
        push_req_out  <= 1'b0;
      end
      // Issue side capture
      if (op_take) begin
        opc_reg   <= op_code_in;
        wdata_reg <= op_wdata_in;
        wr_reg    <= dec_wr;
        nst_reg   <= dec_st;
        transfer_type_field_out <= dec_tt;
        abus_addr_out           <= op_paddr_in;
        burst_indicator_out     <= op_burst_in;
        transfer_size_bits_out  <= op_size_in;
        resource_selector_out   <= is_xfer(op_code_in) ? {op_burst_in, op_size_in} : {`CBO_RSEL_W{1'b0}};
        if (!dec_bus) begin
          // Silent ops update state when dec_wr is set and finish at once
          op_done_out    <= 1'b1;
          state_wr_out   <= dec_wr;
          state_addr_out <= op_paddr_in;
          state_val_out  <= dec_st;
        end
      end
      // Address tenure
      abus_req_out <= (state_next == ST_ADDR);
      if (state_reg == ST_ADDR && abus_ack_in && !address_retry_in && state_next == ST_IDLE) begin
        op_done_out    <= 1'b1;
        state_wr_out   <= wr_reg;
        state_addr_out <= abus_addr_out;
        state_val_out  <= nst_reg;
      end
      // Data tenure steering
      dbus_for_store_out <= 1'b0;
      dbus_for_load_out  <= 1'b0;
      if (dbus_grant_in) begin
        if (write_only_data_grant_qualifier_reg && (store_pending_in || push_pend_reg)) begin
          dbus_for_store_out <= 1'b1;
        end else if (load_pending_in || state_reg == ST_DATA) begin
          dbus_for_load_out <= 1'b1;
        end
      end
      if (state_reg == ST_DATA && dbus_grant_in) begin
        // Exactly one word each way
        op_done_out   <= 1'b1;
        dbus_data_out <= wdata_reg;
        if (opc_reg == `CBO_OP_XFER_RD) begin
          op_rdata_out <= dbus_data_in;
        end
        if (opc_reg == `CBO_OP_DCBT) begin
          state_wr_out   <= 1'b1;
          state_addr_out <= abus_addr_out;
          state_val_out  <= shared_response_in ? `CBO_ST_S : `CBO_ST_E;
        end
      end
    end
  end
endmodule // cbo_bus_ops

// ==== logic/cbo_defines.vh ====
// Constants for the coherency-side bus operation block
`ifndef CBO_DEFINES_VH
`define CBO_DEFINES_VH
// Transfer type codes on the five-bit transfer_type_field
`define CBO_TT_W             5
`define CBO_TT_CLEAN         5'h00
`define CBO_TT_FLUSH         5'h04
`define CBO_TT_SYNC          5'h08
`define CBO_TT_KILL          5'h0C
`define CBO_TT_EIEIO         5'h10
`define CBO_TT_XFER_WRITE    5'h14
`define CBO_TT_TLBSYNC       5'h18
`define CBO_TT_ICBI          5'h1C
`define CBO_TT_WRITE_KILL    5'h06
`define CBO_TT_READ          5'h0A
`define CBO_TT_RD_NO_CACHE   5'h0B
`define CBO_TT_XFER_READ     5'h1B
// Block states (two bits)
`define CBO_ST_W             2
`define CBO_ST_I             2'h0
`define CBO_ST_S             2'h1
`define CBO_ST_E             2'h2
`define CBO_ST_M             2'h3
// Cache control opcodes from instruction issue
`define CBO_OP_W             4
`define CBO_OP_SYNC          4'h1
`define CBO_OP_EIEIO         4'h2
`define CBO_OP_ICBI          4'h3
`define CBO_OP_DCBI          4'h4
`define CBO_OP_DCBF          4'h5
`define CBO_OP_DCBST         4'h6
`define CBO_OP_DCBZ          4'h7
`define CBO_OP_DCBT          4'h8
`define CBO_OP_TLBSYNC       4'h9
`define CBO_OP_XFER_RD       4'hA
`define CBO_OP_XFER_WR       4'hB
// Widths
`define CBO_AW               32
`define CBO_DW               32
`define CBO_RSEL_W           4
`define CBO_TRANSFER_SIZE_BITS_W           3
`endif

// ==== logic/cbo_op_decode.v ====
// Cache control opcode to bus operation and next block state decoder
`timescale 1ns/1ps
`include "cbo_defines.vh"
module cbo_op_decode (
  // Request
  input  wire [`CBO_OP_W-1:0] op_in,
  input  wire [`CBO_ST_W-1:0] state_in,
  // Decoded result
  output reg                  bus_op_out,
  output reg  [`CBO_TT_W-1:0] tt_out,
  output reg                  state_wr_out,
  output reg  [`CBO_ST_W-1:0] state_next_out,
  output reg                  drain_out
);
  // Pure combinational lookup
  always @* begin
    bus_op_out     = 1'b1;
    tt_out         = `CBO_TT_CLEAN;
    state_wr_out   = 1'b0;
    state_next_out = state_in;
    drain_out      = 1'b0;
    case (op_in)
      `CBO_OP_SYNC: begin
        tt_out    = `CBO_TT_SYNC;
        drain_out = 1'b1;
      end
      `CBO_OP_EIEIO:   tt_out = `CBO_TT_EIEIO;
      `CBO_OP_TLBSYNC: tt_out = `CBO_TT_TLBSYNC;
      `CBO_OP_ICBI: begin
        tt_out         = `CBO_TT_ICBI;
        state_wr_out   = 1'b1;
        state_next_out = `CBO_ST_I;
      end
      `CBO_OP_DCBI: begin
        tt_out         = `CBO_TT_KILL;
        state_wr_out   = 1'b1;
        state_next_out = `CBO_ST_I;
      end
      `CBO_OP_DCBF: begin
        // Modified data goes out write-through before invalidation
        tt_out         = (state_in == `CBO_ST_M) ? `CBO_TT_WRITE_KILL : `CBO_TT_FLUSH;
        state_wr_out   = 1'b1;
        state_next_out = `CBO_ST_I;
      end
      `CBO_OP_DCBST: begin
        tt_out         = (state_in == `CBO_ST_M) ? `CBO_TT_WRITE_KILL : `CBO_TT_CLEAN;
        state_wr_out   = (state_in == `CBO_ST_M);
        state_next_out = `CBO_ST_E;
      end
      `CBO_OP_DCBZ: begin
        // Owned blocks are zeroed silently
        bus_op_out     = (state_in == `CBO_ST_I) || (state_in == `CBO_ST_S);
        tt_out         = `CBO_TT_KILL;
        state_wr_out   = 1'b1;
        state_next_out = `CBO_ST_M;
      end
      `CBO_OP_DCBT: begin
        // Final state comes with the reload
        bus_op_out = (state_in == `CBO_ST_I);
        tt_out     = `CBO_TT_READ;
      end
      `CBO_OP_XFER_RD: tt_out = `CBO_TT_XFER_READ;
      `CBO_OP_XFER_WR: tt_out = `CBO_TT_XFER_WRITE;
      default: bus_op_out = 1'b0; // Unknown opcode, no bus op
    endcase
  end
endmodule // cbo_op_decode

// ==== dv/cbo_bus_ops_checker.sv ====
// Checker: bus operation engine port relations
`timescale 1ns/1ps
`include "cbo_defines.vh"
module cbo_bus_ops_checker (
  // Clock and reset
  input wire                    ref_clk_in,
  input wire                    rst_in,
  // Issue and memory queue
  input wire                    op_done_out,
  input wire                    memq_empty_in,
  input wire                    load_pending_in,
  input wire                    store_pending_in,
  // Address bus
  input wire                    abus_req_out,
  input wire [`CBO_TT_W-1:0]    transfer_type_field_out,
  input wire                    burst_indicator_out,
  input wire [`CBO_TRANSFER_SIZE_BITS_W-1:0]  transfer_size_bits_out,
  input wire [`CBO_RSEL_W-1:0]  resource_selector_out,
  input wire                    push_req_out,
  input wire                    abus_ack_in,
  input wire                    address_retry_in,
  // Snoop and tag update
  input wire                    snp_valid_in,
  input wire [`CBO_TT_W-1:0]    snp_tt_in,
  input wire [`CBO_ST_W-1:0]    snp_state_in,
  input wire                    state_wr_out,
  input wire [`CBO_ST_W-1:0]    state_val_out,
  input wire                    address_retry_out,
  // Data bus
  input wire                    dbus_grant_in,
  input wire                    write_only_data_grant_qualifier_n_in,
  input wire                    dbus_for_store_out,
  input wire                    dbus_for_load_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Qualifier must sit five cycles to clear the three-stage sync
  wire q_n = write_only_data_grant_qualifier_n_in;
  wire xfer_w = abus_req_out && (transfer_type_field_out == `CBO_TT_XFER_READ ||
                                 transfer_type_field_out == `CBO_TT_XFER_WRITE);
  property p_rsel; xfer_w |-> resource_selector_out == {burst_indicator_out, transfer_size_bits_out}; endproperty
  a_rsel: assert property (p_rsel) else $error("selector not burst plus size");
  property p_nocache; snp_valid_in && snp_tt_in == `CBO_TT_RD_NO_CACHE && snp_state_in == `CBO_ST_M
    |=> state_wr_out && state_val_out == `CBO_ST_E && push_req_out; endproperty
  a_nocache: assert property (p_nocache) else $error("no-cache read on modified not pushed");
  property p_sync_rty; snp_valid_in && snp_tt_in == `CBO_TT_SYNC && push_req_out |=> address_retry_out; endproperty
  a_sync_rty: assert property (p_sync_rty) else $error("barrier snoop not retried");
  property p_load_def; q_n[*5] ##0 (dbus_grant_in && load_pending_in && store_pending_in && !push_req_out)
    |=> dbus_for_load_out && !dbus_for_store_out; endproperty
  a_load_def: assert property (p_load_def) else $error("default tenure not for load");
  property p_store_q; (!q_n)[*5] ##0 (dbus_grant_in && store_pending_in)
    |=> dbus_for_store_out && !dbus_for_load_out; endproperty
  a_store_q: assert property (p_store_q) else $error("qualified tenure not for store");
  property p_no_store; (!q_n)[*5] ##0 (dbus_grant_in && load_pending_in && !store_pending_in && !push_req_out)
    |=> dbus_for_load_out && !dbus_for_store_out; endproperty
  a_no_store: assert property (p_no_store) else $error("qualified tenure without store not for load");
  property p_drain; $rose(abus_req_out) && transfer_type_field_out == `CBO_TT_SYNC |-> $past(memq_empty_in); endproperty
  a_drain: assert property (p_drain) else $error("barrier issued before queue drained");
  property p_self_rty; abus_req_out && abus_ack_in && address_retry_in |=> !op_done_out ##[0:8] abus_req_out; endproperty
  a_self_rty: assert property (p_self_rty) else $error("retried operation not reissued");
endmodule // cbo_bus_ops_checker

// ==== dv/cbo_sys_bus_model.sv ====
// Partner: arbiter and memory answering address and data tenures
`timescale 1ns/1ps
`include "cbo_defines.vh"
module cbo_sys_bus_model #(
  parameter logic [31:0] WORD = 32'hC0DE_5A17  // Word served on external reads
) (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  // Device requests; address is never decoded
  input  wire logic        req_in,
  input  wire logic        push_in,
  input  wire logic [4:0]  tt_in,
  // Test controls
  input  wire logic [3:0]  delay_in,
  input  wire logic        retry_in,
  input  wire logic        kick_in,
  // Answers
  output logic             ack_out,
  output logic             retry_out,
  output logic             grant_out,
  output logic [31:0]      data_out
);
  logic [3:0] cnt;      // Address tenure wait
  logic [1:0] gcnt;     // Gap to data tenure
  logic       retried;  // One retry per request
  wire data_tt = push_in || tt_in == `CBO_TT_READ || tt_in == `CBO_TT_WRITE_KILL ||
                 tt_in == `CBO_TT_XFER_READ || tt_in == `CBO_TT_XFER_WRITE;
  // Ack after a chosen wait, optional retry, then grant for data-carrying requests not retried
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      {cnt, gcnt, retried, ack_out, retry_out, grant_out} <= '0;
      data_out <= 32'h0;
    end else begin
      {ack_out, retry_out, grant_out} <= 3'h0;
      data_out <= ~data_out;  // Idle bus never keeps a stale word
      if (!req_in) retried <= 1'b0;
      if (gcnt != 2'h0) gcnt <= gcnt - 2'h1;
      if (gcnt == 2'h1 || kick_in) begin
        grant_out <= 1'b1;
        data_out <= WORD;
      end
      if (req_in && !ack_out) begin
        if (cnt >= delay_in) begin
          cnt <= 4'h0;
          ack_out <= 1'b1;
          retry_out <= retry_in && !retried;
          retried <= retry_in;
          if (!(retry_in && !retried) && data_tt) gcnt <= 2'h2;
        end else cnt <= cnt + 4'h1;
      end
    end
  end
endmodule // cbo_sys_bus_model

// ==== dv/tb.sv ====
// Testbench: cache ops, external transfers, snoops and data grants
`timescale 1ns/1ps
`include "cbo_defines.vh"
module tb;
  // Design inputs and model controls
  logic        ref_clk_in = 1'b0, rst_in = 1'b1, op_valid_in = 1'b0, op_burst_in = 1'b0;
  logic        memq_empty_in = 1'b1, load_pending_in = 1'b0, store_pending_in = 1'b0;
  logic        snp_valid_in = 1'b0, shared_response_in = 1'b0, m_retry = 1'b0, m_kick = 1'b0;
  logic        write_only_data_grant_qualifier_n_in = 1'b1;
  logic [3:0]  op_code_in = 4'h0, m_delay = 4'h1;
  logic [31:0] op_paddr_in = 32'h0, op_wdata_in = 32'h0, snp_addr_in = 32'h0000_1040;
  logic [2:0]  op_size_in = 3'h0;
  logic [1:0]  op_state_in = 2'h0, snp_state_in = 2'h0;
  logic [4:0]  snp_tt_in = 5'h00;
  // Design outputs and model answers
  wire         op_ready_out, op_done_out, state_wr_out, abus_req_out, burst_indicator_out, push_req_out;
  wire         abus_ack_in, address_retry_in, address_retry_out, dbus_grant_in, dbus_for_store_out, dbus_for_load_out;
  wire [31:0]  op_rdata_out, state_addr_out, abus_addr_out, dbus_data_in, dbus_data_out;
  wire [4:0]   transfer_type_field_out;
  wire [2:0]   transfer_size_bits_out;
  wire [3:0]   resource_selector_out;
  wire [1:0]   state_val_out;
  // Scoreboard
  int          fail_count = 0, tests_run = 0, acks, n;
  logic [4:0]  got_tt;
  logic [3:0]  got_rsel;
  logic [1:0]  st, s_val;
  logic [31:0] got_addr, got_rd;
  logic        s_wr, s_rt, s_push;
  // {op, state, bus code, end state, shared}; code 5'h1F means no bus operation
  logic [13:0] tbl [20] = '{14'h0542, 14'h0A84, 14'h27C6, 14'h0DE0, 14'h1360, 14'h1620, 14'h1520,
    14'h1420, 14'h1730, 14'h1A04, 14'h1902, 14'h1B34, 14'h1C66, 14'h1D66, 14'h1FFE, 14'h1EFE,
    14'h2054, 14'h2053, 14'h22FC, 14'h21FA};
  cbo_bus_ops DUT (.*);
  cbo_sys_bus_model u_bus (.ref_clk_in, .rst_in, .req_in(abus_req_out | push_req_out), .push_in(push_req_out),
    .tt_in(transfer_type_field_out), .delay_in(m_delay), .retry_in(m_retry), .kick_in(m_kick),
    .ack_out(abus_ack_in), .retry_out(address_retry_in), .grant_out(dbus_grant_in), .data_out(dbus_data_in));
  always #12.5 ref_clk_in = ~ref_clk_in;
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One issued op; queue drains four cycles after issue
  task automatic do_op(input logic [13:0] row);
    got_tt = 5'h1F;
    st = row[9:8];
    acks = 0;
    @(posedge ref_clk_in);
    {op_code_in, op_state_in, shared_response_in} <= {row[13:8], row[0]};
    memq_empty_in <= 1'b0;
    op_valid_in <= 1'b1;
    n = 0;
    do @(posedge ref_clk_in); while (op_ready_out !== 1'b1 && ++n < 60);
    op_valid_in <= 1'b0;
    n = 0;
    while (op_done_out !== 1'b1 && n < 80) begin
      @(posedge ref_clk_in);
      n++;
      if (n == 4) memq_empty_in <= 1'b1;
      if (abus_req_out === 1'b1 && got_tt === 5'h1F) {got_tt, got_rsel, got_addr} = {transfer_type_field_out,
        resource_selector_out, abus_addr_out};
      if (abus_ack_in === 1'b1) acks++;
      if (state_wr_out === 1'b1) st = state_val_out;
    end
    got_rd = op_rdata_out;
    chk(op_done_out, 1'b1);
  endtask
  // One snoop; outputs read in the following cycle
  task automatic snoop(input logic [4:0] tt, input logic [1:0] s);
    @(posedge ref_clk_in);
    {snp_valid_in, snp_tt_in, snp_state_in} <= {1'b1, tt, s};
    @(posedge ref_clk_in);
    snp_valid_in <= 1'b0;
    @(posedge ref_clk_in);
    {s_wr, s_val, s_rt, s_push} = {state_wr_out, state_val_out, address_retry_out, push_req_out};
  endtask
  // {load, store, qualifier low}, settle past the sync, then one grant
  task automatic grant(input logic [2:0] lsq, input logic [1:0] exp);
    @(posedge ref_clk_in);
    {load_pending_in, store_pending_in, write_only_data_grant_qualifier_n_in} <= lsq ^ 3'h1;
    repeat (6) @(posedge ref_clk_in);
    m_kick <= 1'b1;
    @(posedge ref_clk_in);
    m_kick <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    chk({dbus_for_store_out, dbus_for_load_out}, exp);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    for (int i = 0; i < 20; i++) begin
      do_op(tbl[i]);
      chk(got_tt, tbl[i][7:3]);
      chk(st, tbl[i][2:1]);
    end
    m_retry <= 1'b1;
    do_op(tbl[3]);
    m_retry <= 1'b0;
    chk(acks, 2);
    {op_paddr_in, op_burst_in, op_size_in} <= {32'h0000_2A40, 1'b1, 3'h5};
    do_op({`CBO_OP_XFER_RD, 2'h0, `CBO_TT_XFER_READ, 3'h0});
    chk({got_tt, got_rsel}, {`CBO_TT_XFER_READ, 4'hD});
    chk(got_addr, 32'h0000_2A40);
    chk(got_rd, 32'hC0DE_5A17);
    {op_burst_in, op_size_in, op_wdata_in} <= {1'b0, 3'h2, 32'h1234_5678};
    do_op({`CBO_OP_XFER_WR, 2'h0, `CBO_TT_XFER_WRITE, 3'h0});
    chk({got_tt, got_rsel}, {`CBO_TT_XFER_WRITE, 4'h2});
    m_delay <= 4'h8;
    snoop(`CBO_TT_RD_NO_CACHE, `CBO_ST_M);
    chk({s_wr, s_val, s_push}, {1'b1, `CBO_ST_E, 1'b1});
    snoop(`CBO_TT_SYNC, `CBO_ST_I);
    chk(s_rt, 1'b1);
    n = 0;
    while (push_req_out !== 1'b0 && n++ < 100) @(posedge ref_clk_in);
    chk(push_req_out, 1'b0);
    snoop(`CBO_TT_SYNC, `CBO_ST_I);
    chk(s_rt, 1'b0);
    snoop(`CBO_TT_KILL, `CBO_ST_S);
    chk({s_wr, s_val}, {1'b1, `CBO_ST_I});
    snoop(`CBO_TT_RD_NO_CACHE, `CBO_ST_E);
    chk(s_push, 1'b0);
    m_delay <= 4'h1;
    grant(3'h6, 2'h1);
    grant(3'h7, 2'h2);
    grant(3'h5, 2'h1);
    grant(3'h3, 2'h2);
    wrap_up;
  end
  // Hang guard well past the longest expected run
  initial begin
    #(25 * 20000);
    fail_count++;
    wrap_up;
  end
endmodule // tb
bind cbo_bus_ops cbo_bus_ops_checker u_chk (.*);
